// ### design/ulmc_line_modem.sv
/*
 * ulmc_line_modem: line format, modem control, first xon character and
 * upper line status of a single-channel uart, with the character
 * transmitter that these registers steer and a receive break detector.
 * assumes: one clock mclk (100 MHz), synchronous resets (rst_n, por_n active low, sw_rst active high), the host
 * port decoder presents single-cycle register strobes; the page select flag,
 * enhanced enable, auto-rts and divisor come from neighbouring blocks.
 */
`timescale 1ns/1ps
`default_nettype none
module ulmc_line_modem #(
	parameter int ERR_CNT_W = 7
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        por_n,
	input  wire logic        sw_rst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic [7:0]       reg_rdata,
	output logic             reg_rvalid,
	input  wire logic        page_sel,
	input  wire logic        enh_enable,
	input  wire logic        auto_rts_en,
	input  wire logic        auto_rts_level,
	input  wire logic [15:0] baud_div,
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	output logic             tx_out,
	input  wire logic        rx_pin,
	output logic             rx_line,
	input  wire logic        rx_char_valid,
	input  wire logic        rx_char_is_flow,
	input  wire logic        rx_sw_flow_on,
	output logic             rx_fifo_load,
	output logic             tx_resume,
	input  wire logic        rx_err_push,
	input  wire logic        rx_err_pop,
	input  wire logic        cts_n_pin,
	input  wire logic        dsr_n_pin,
	input  wire logic        ri_n_pin,
	input  wire logic        carrier_detect_n_pin,
	output logic [3:0]       modem_state,
	output logic             sel_flow_regs,
	output logic             rts_n_pin,
	output logic             dtr_n_pin,
	output logic             sleep_allow
);
	import ulmc_pkg::*;

	logic [7:0] line_format;
	logic [7:0] modem_control;
	logic [7:0] xon_first_char;
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic [ERR_CNT_W-1:0] err_cnt;
	logic       brk_flag;
	logic       brk_armed;
	logic [9:0] low_ticks;
	logic [1:0] presc_cnt;
	logic [15:0] div_cnt;
	logic [7:0] buf_mem [2];
	logic       buf_wp;
	logic       buf_rp;
	logic [1:0] buf_cnt;
	ulmc_tx_state_t tx_state;
	logic [7:0] shift;
	logic [2:0] bit_idx;
	logic [5:0] sub_cnt;
	logic       tx_bit;

	wire soft_rst = ~rst_n | sw_rst;
	wire dlab     = line_format[ULMC_LF_DLAB];
	wire loop     = modem_control[ULMC_MC_LOOP];
	wire irda     = modem_control[ULMC_MC_IRDA];

	// register decode; line format is always reachable
	wire sel_lf   = reg_addr == ULMC_OFF_LINE_FORMAT;
	wire sel_mc   = reg_addr == ULMC_OFF_MODEM_CTRL && !dlab;
	wire sel_xon  = reg_addr == ULMC_OFF_MODEM_CTRL && line_format == ULMC_ENHANCED_KEY
		&& !page_sel;
	wire sel_ls   = reg_addr == ULMC_OFF_LINE_STATUS && !dlab;
	wire wr_lf    = reg_wr && sel_lf;
	wire wr_mc    = reg_wr && sel_mc;
	wire wr_xon   = reg_wr && sel_xon;
	wire rd_ls    = reg_rd && sel_ls;

	// protected bits keep their value unless the enhanced enable is set
	wire [7:0] mc_keep = enh_enable ? 8'h00 : ULMC_MCR_PROTECT_MASK;
	wire [7:0] next_mc = (modem_control & mc_keep) | (reg_wdata & ~mc_keep);
	assign sleep_allow = enh_enable;

	always_ff @(posedge mclk) begin
		if (soft_rst) begin
			line_format   <= ULMC_LINE_FORMAT_RST;
			modem_control <= ULMC_MODEM_CTRL_RST;
		end else begin
			if (wr_lf)
				line_format <= reg_wdata;
			if (wr_mc)
				modem_control <= next_mc;
		end
	end

	// survives hardware and soft reset; only power-on clears it
	always_ff @(posedge mclk) begin
		if (!por_n)
			xon_first_char <= ULMC_XON_FIRST_RST;
		else if (wr_xon)
			xon_first_char <= reg_wdata;
	end

	// pins from outside: two flops before use
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sync1 <= 5'h1F;
			sync2 <= 5'h1F;
		end else begin
			sync1 <= {rx_pin, cts_n_pin, dsr_n_pin, ri_n_pin, carrier_detect_n_pin};
			sync2 <= sync1;
		end
	end

	// modem state upper nibble: carrier, ring, dsr, cts
	wire [3:0] pin_state  = ~{sync2[0], sync2[1], sync2[2], sync2[3]};
	wire [3:0] loop_state = {modem_control[ULMC_MC_OUT2], modem_control[ULMC_MC_OUT1],
		modem_control[ULMC_MC_DTR], modem_control[ULMC_MC_RTS]};
	assign modem_state   = loop ? loop_state : pin_state;
	assign sel_flow_regs = !loop && modem_control[ULMC_MC_OUT1];
	// in loopback dtr keeps its inactive level, and rts does too unless auto-rts drives it
	assign rts_n_pin = auto_rts_en ? auto_rts_level
		: (loop | ~modem_control[ULMC_MC_RTS]);
	assign dtr_n_pin = loop | ~modem_control[ULMC_MC_DTR];

	// receive path; the infrared receiver sees a high pulse for a zero
	wire rx_pin_line = irda ? ~sync2[4] : sync2[4];
	assign rx_line   = loop ? tx_bit : rx_pin_line;

	// xon-any: any character restarts a halted transmitter
	assign tx_resume    = modem_control[ULMC_MC_XANY] && rx_char_valid;
	assign rx_fifo_load = rx_char_valid && !(rx_char_is_flow && rx_sw_flow_on);

	// baud tick: optional divide by four, then the divisor, giving 16x ticks
	wire presc_tick = !modem_control[ULMC_MC_PRESC] || presc_cnt == ULMC_PRESC_LAST;
	wire div_last   = div_cnt >= baud_div - 16'h0001;
	wire tick16     = presc_tick && div_last;

	always_ff @(posedge mclk) begin
		if (soft_rst) begin
			presc_cnt <= 2'h0;
			div_cnt   <= 16'h0000;
		end else begin
			presc_cnt <= presc_cnt + 2'h1;
			if (presc_tick)
				div_cnt <= div_last ? 16'h0000 : div_cnt + 16'h0001;
		end
	end

	// frame geometry from the line format
	// index of the last data bit: codes 00..11 give bit 4..7
	wire [2:0] last_bit = {1'b1, line_format[1:0]};
	wire       par_en   = line_format[ULMC_LF_PAR_EN];
	wire [7:0] len_mask = 8'hFF >> (3'd3 - {1'b0, line_format[1:0]});
	wire [5:0] stop_len = !line_format[ULMC_LF_STOP] ? ULMC_TICKS_BIT
		: (line_format[1:0] == 2'b00 ? ULMC_TICKS_STOP_1P5 : ULMC_TICKS_STOP_2);

	// two-entry holding buffer: a busy shifter never drops a written byte
	wire buf_push = tx_valid && tx_ready;
	wire buf_pop  = tx_state == ULMC_TX_IDLE && buf_cnt != 2'h0;
	assign tx_ready = buf_cnt != ULMC_BUF_DEPTH[1:0];

	always_ff @(posedge mclk) begin
		if (soft_rst) begin
			buf_wp  <= 1'b0;
			buf_rp  <= 1'b0;
			buf_cnt <= 2'h0;
		end else begin
			if (buf_push)
				buf_wp <= ~buf_wp;
			if (buf_pop)
				buf_rp <= ~buf_rp;
			buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end

	always_ff @(posedge mclk) begin
		if (buf_push)
			buf_mem[buf_wp] <= tx_data;
	end

	// parity over the character's own bits
	wire data_xor   = ^(shift & len_mask);
	wire parity_bit = line_format[ULMC_LF_FORCE] ? ~line_format[ULMC_LF_EVEN]
		: (line_format[ULMC_LF_EVEN] ? data_xor : ~data_xor);
	wire [5:0] phase_len = tx_state == ULMC_TX_STOP ? stop_len : ULMC_TICKS_BIT;
	wire       phase_end = tick16 && sub_cnt == phase_len - 6'd1;

	always_ff @(posedge mclk) begin
		if (soft_rst) begin
			tx_state <= ULMC_TX_IDLE;
			shift    <= 8'h00;
			bit_idx  <= 3'h0;
			sub_cnt  <= 6'h00;
		end else begin
			if (tick16)
				sub_cnt <= phase_end ? 6'h00 : sub_cnt + 6'd1;
			unique case (tx_state)
				ULMC_TX_IDLE: begin
					sub_cnt <= 6'h00;
					if (buf_pop) begin
						shift    <= buf_mem[buf_rp];
						tx_state <= ULMC_TX_START;
					end
				end
				ULMC_TX_START: begin
					bit_idx <= 3'h0;
					if (phase_end)
						tx_state <= ULMC_TX_DATA;
				end
				ULMC_TX_DATA: begin
					if (phase_end) begin
						bit_idx <= bit_idx + 3'd1;
						if (bit_idx == last_bit)
							tx_state <= par_en ? ULMC_TX_PARITY : ULMC_TX_STOP;
					end
				end
				ULMC_TX_PARITY: begin
					if (phase_end)
						tx_state <= ULMC_TX_STOP;
				end
				ULMC_TX_STOP: begin
					if (phase_end)
						tx_state <= ULMC_TX_IDLE;
				end
			endcase
		end
	end

	wire next_tx_bit = tx_state == ULMC_TX_START ? 1'b0
		: tx_state == ULMC_TX_DATA ? shift[bit_idx]
		: tx_state == ULMC_TX_PARITY ? parity_bit : 1'b1;
	// infrared sends a short high pulse at the start of every zero bit
	wire next_ir    = !next_tx_bit && sub_cnt < ULMC_IR_PULSE_TICKS && tx_state != ULMC_TX_IDLE;
	wire next_brk   = line_format[ULMC_LF_BREAK];
	wire next_txout = next_brk ? 1'b0 : (irda ? next_ir : next_tx_bit);

	always_ff @(posedge mclk) begin
		if (soft_rst) begin
			tx_bit <= 1'b1;
			tx_out <= 1'b1;
		end else begin
			tx_bit <= next_brk ? 1'b0 : next_tx_bit;
			tx_out <= next_txout;
		end
	end

	// break detector: line low for a whole frame, caught once per low period
	wire [9:0] frame_ticks = {4'h0, ULMC_TICKS_BIT} * ({7'h0, last_bit} + 10'd2 + {9'h0, par_en})
		+ {4'h0, stop_len};
	wire brk_hit = tick16 && !rx_line && brk_armed && low_ticks == frame_ticks - 10'd1;

	always_ff @(posedge mclk) begin
		if (soft_rst) begin
			low_ticks <= 10'h000;
			brk_armed <= 1'b1;
			brk_flag  <= 1'b0;
		end else begin
			if (rx_line) begin
				low_ticks <= 10'h000;
				brk_armed <= 1'b1;
			end else if (tick16 && brk_armed) begin
				low_ticks <= low_ticks + 10'd1;
				if (brk_hit)
					brk_armed <= 1'b0;
			end
			// a new break wins over the clearing read
			brk_flag <= brk_hit | (brk_flag & ~rd_ls);
		end
	end

	// error characters held in the receive fifo
	always_ff @(posedge mclk) begin
		if (soft_rst)
			err_cnt <= '0;
		else if (rx_err_push && !rx_err_pop)
			err_cnt <= err_cnt + ERR_CNT_W'(1);
		else if (rx_err_pop && !rx_err_push && err_cnt != '0)
			err_cnt <= err_cnt - ERR_CNT_W'(1);
	end

	wire hold_empty = buf_cnt == 2'h0;
	wire [7:0] line_status = {err_cnt != '0,
		hold_empty && tx_state == ULMC_TX_IDLE,
		hold_empty,
		brk_flag, 4'h0};

	wire [7:0] rd_mux = sel_lf ? line_format : sel_mc ? modem_control
		: sel_xon ? xon_first_char : sel_ls ? line_status : 8'h00;

	always_ff @(posedge mclk) begin
		if (soft_rst) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= rd_mux;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n || sw_rst);

	sequence brk_held_s;
		line_format[ULMC_LF_BREAK] [*2];
	endsequence

	break_low_a: assert property (brk_held_s |-> !tx_out)
		else $error("break set but transmit output high");
	parity_gate_a: assert property (tx_state == ULMC_TX_DATA && phase_end && bit_idx == last_bit
		|=> (tx_state == ULMC_TX_PARITY) == $past(par_en))
		else $error("parity phase does not follow parity enable");
	mc_guard_a: assert property (reg_wr && !sel_mc && !(sel_lf && soft_rst)
		|=> $stable(modem_control))
		else $error("modem control changed without access");
	protect_bits_a: assert property (wr_mc && !enh_enable
		|=> (modem_control & ULMC_MCR_PROTECT_MASK) == $past(modem_control & ULMC_MCR_PROTECT_MASK))
		else $error("protected modem bits written without enable");
	rts_drive_a: assert property (!auto_rts_en && !loop |-> rts_n_pin == !modem_control[ULMC_MC_RTS])
		else $error("rts pin does not follow control bit");
	loop_status_a: assert property (loop |-> modem_state == loop_state && !sel_flow_regs)
		else $error("loopback status mismatch");
	xany_load_a: assert property (rx_char_valid && rx_char_is_flow && rx_sw_flow_on
		|-> !rx_fifo_load && (tx_resume == modem_control[ULMC_MC_XANY]))
		else $error("xon-any handling wrong");
	hold_empty_a: assert property (buf_pop && buf_cnt == 2'h1 && !buf_push
		|=> line_status[ULMC_LS_HOLD_MT] && !line_status[ULMC_LS_TX_IDLE])
		else $error("holding empty not set on transfer");
	err_flag_a: assert property (err_cnt == '0 && rx_err_push && !rx_err_pop
		|=> line_status[ULMC_LS_FIFO_ERR])
		else $error("fifo error flag not set");
	brk_flag_a: assert property (brk_hit |=> brk_flag)
		else $error("break flag lost");
endmodule // ulmc_line_modem
`default_nettype wire

// ### design/ulmc_pkg.sv
/*
 * ulmc_pkg: register offsets, field positions, reset values and timing
 * constants of the uart line and modem control block.
 * assumes: included by the block's only design module.
 */
`default_nettype none
package ulmc_pkg;
	localparam logic [3:0] ULMC_OFF_LINE_FORMAT  = 4'h3;
	localparam logic [3:0] ULMC_OFF_MODEM_CTRL   = 4'h4;
	localparam logic [3:0] ULMC_OFF_LINE_STATUS  = 4'h5;
	localparam logic [7:0] ULMC_LINE_FORMAT_RST  = 8'h1D;
	localparam logic [7:0] ULMC_MODEM_CTRL_RST   = 8'h00;
	localparam logic [7:0] ULMC_LINE_STATUS_RST  = 8'h60;
	localparam logic [7:0] ULMC_XON_FIRST_RST    = 8'h00;
	localparam logic [7:0] ULMC_ENHANCED_KEY     = 8'hBF;
	localparam logic [7:0] ULMC_MCR_PROTECT_MASK = 8'hEC;
	// line format fields
	localparam int ULMC_LF_DLAB   = 7;
	localparam int ULMC_LF_BREAK  = 6;
	localparam int ULMC_LF_FORCE  = 5;
	localparam int ULMC_LF_EVEN   = 4;
	localparam int ULMC_LF_PAR_EN = 3;
	localparam int ULMC_LF_STOP   = 2;
	// modem control fields
	localparam int ULMC_MC_PRESC  = 7;
	localparam int ULMC_MC_IRDA   = 6;
	localparam int ULMC_MC_XANY   = 5;
	localparam int ULMC_MC_LOOP   = 4;
	localparam int ULMC_MC_OUT2   = 3;
	localparam int ULMC_MC_OUT1   = 2;
	localparam int ULMC_MC_RTS    = 1;
	localparam int ULMC_MC_DTR    = 0;
	// line status fields
	localparam int ULMC_LS_FIFO_ERR = 7;
	localparam int ULMC_LS_TX_IDLE  = 6;
	localparam int ULMC_LS_HOLD_MT  = 5;
	localparam int ULMC_LS_BREAK    = 4;
	// timing, in 16x sample ticks; prescaler last count and holding buffer depth
	localparam logic [5:0] ULMC_TICKS_BIT      = 6'd16;
	localparam logic [5:0] ULMC_TICKS_STOP_1P5 = 6'd24;
	localparam logic [5:0] ULMC_TICKS_STOP_2   = 6'd32;
	localparam logic [5:0] ULMC_IR_PULSE_TICKS = 6'd3;
	localparam logic [1:0] ULMC_PRESC_LAST     = 2'h3;
	localparam logic [3:0] ULMC_BUF_DEPTH      = 4'h2;
	typedef enum logic [2:0] {
		ULMC_TX_IDLE   = 3'b000,
		ULMC_TX_START  = 3'b001,
		ULMC_TX_DATA   = 3'b010,
		ULMC_TX_PARITY = 3'b011,
		ULMC_TX_STOP   = 3'b100
	} ulmc_tx_state_t;
endpackage
`default_nettype wire

// ### tb/ulmc_remote_dev.sv
/*
 * ulmc_remote_dev: behavioural far-side serial device. It decodes the frames
 * on the block's transmit pin and can pull the block's receive line low.
 * assumes: one frame format at a time, given in clocks per bit and sampled bits.
 */
`timescale 1ns/1ps
`default_nettype none
module ulmc_remote_dev (
	input  wire logic       mclk,
	input  wire logic       ser_in,
	input  wire logic [6:0] bit_clks,
	input  wire logic [3:0] n_bits,
	input  wire logic       hold_low,
	output logic            rx_pin,
	output logic            char_done,
	output logic [8:0]      char_bits,
	output logic [7:0]      gap
);
	int i;
	int idle;

	// line has a pull-up: idle mark level unless a break is being sent
	assign rx_pin = ~hold_low;

	initial begin
		char_done = 1'b0;
		char_bits = '0;
		gap = '0;
		idle = 0;
		forever begin
			// sample on the falling edge, clear of the edge that launches the pin
			@(negedge mclk);
			if (ser_in === 1'b1) begin
				idle = idle + 1;
			end else if (idle > 0) begin
				char_bits = '0;
				repeat (bit_clks / 2) @(negedge mclk);
				if (ser_in !== 1'b0) begin
					// low for less than half a bit: a glitch, not a start bit
					idle = 0;
				end else begin
					// idle high time before this start bit shows the previous stop length
					gap = (idle > 255) ? 8'hFF : 8'(idle);
					for (i = 0; i < n_bits; i++) begin
						repeat (bit_clks) @(negedge mclk);
						char_bits[i] = ser_in;
					end
					repeat (bit_clks / 2) @(negedge mclk);
					@(posedge mclk);
					char_done = 1'b1;
					@(posedge mclk);
					char_done = 1'b0;
					idle = 2;
				end
			end
		end
	end
endmodule // ulmc_remote_dev
`default_nettype wire

// ### tb/tb_ulmc_line_modem.sv
/*
 * tb_ulmc_line_modem: self-checking bench for the line and modem control block.
 * assumes: baud divisor of one, so a bit lasts 16 clocks without prescaling.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_ulmc_line_modem;
	import ulmc_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_n, por_n, sw_rst, reg_wr, reg_rd, page_sel, enh_enable;
	logic        auto_rts_en, auto_rts_level, tx_valid, rx_char_valid, rx_char_is_flow;
	logic        rx_sw_flow_on, rx_err_push, rx_err_pop, hold_low;
	logic [3:0]  reg_addr, mpin, n_bits;
	logic [7:0]  reg_wdata, tx_data, reg_rdata, gap;
	logic [6:0]  bit_clks;
	logic        reg_rvalid, tx_ready, tx_out, rx_pin, rx_line, rx_fifo_load, tx_resume;
	logic        sel_flow_regs, rts_n_pin, dtr_n_pin, char_done, sleep_allow;
	logic [3:0]  modem_state;
	logic [8:0]  char_bits;
	logic [31:0] seed = 32'hE84DE2E9;
	int          n_errors = 0;
	int          n_compared = 0;
	logic [7:0]  rd_q[$];
	logic [16:0] ch_q[$];
	logic [7:0]  fmt[6] = '{8'h03, 8'h0B, 8'h1E, 8'h2D, 8'h3C, 8'h04};
	int          i;

	always #5 mclk = ~mclk;

	ulmc_line_modem u_ulmc_line_modem (.mclk(mclk), .rst_n(rst_n), .por_n(por_n), .sw_rst(sw_rst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .page_sel(page_sel), .enh_enable(enh_enable), .auto_rts_en(auto_rts_en),
		.auto_rts_level(auto_rts_level), .baud_div(16'h0001), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_out(tx_out), .rx_pin(rx_pin), .rx_line(rx_line), .rx_char_valid(rx_char_valid),
		.rx_char_is_flow(rx_char_is_flow), .rx_sw_flow_on(rx_sw_flow_on), .rx_fifo_load(rx_fifo_load),
		.tx_resume(tx_resume), .rx_err_push(rx_err_push), .rx_err_pop(rx_err_pop), .cts_n_pin(mpin[0]),
		.dsr_n_pin(mpin[1]), .ri_n_pin(mpin[2]), .carrier_detect_n_pin(mpin[3]), .modem_state(modem_state),
		.sel_flow_regs(sel_flow_regs), .rts_n_pin(rts_n_pin), .dtr_n_pin(dtr_n_pin), .sleep_allow(sleep_allow));

	ulmc_remote_dev u_ulmc_remote_dev (.mclk(mclk), .ser_in(tx_out), .bit_clks(bit_clks), .n_bits(n_bits),
		.hold_low(hold_low), .rx_pin(rx_pin), .char_done(char_done), .char_bits(char_bits), .gap(gap));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	task automatic finish_test;
		if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask

	// the expected value is queued here and compared when read data comes back
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		rd_q.push_back(e);
		@(negedge mclk);
		reg_rd = 1'b0;
		@(negedge mclk);
	endtask

	// one random character; the expected frame bits and stop gap go to the queue
	task automatic send(input logic [7:0] lf, input logic [7:0] stop_c);
		logic [8:0] e;
		int nb;
		int k;
		nb = 5 + int'(lf[1:0]);
		seed = xs(seed);
		e = {1'b0, seed[7:0] & (8'hFF >> (8 - nb))};
		if (lf[3]) e[nb] = lf[5] ? ~lf[4] : (lf[4] ? ^e : ~^e);
		ch_q.push_back({stop_c, e});
		@(negedge mclk);
		tx_data = seed[7:0];
		tx_valid = 1'b1;
		for (k = 0; k < 3000 && tx_ready !== 1'b1; k++) @(negedge mclk);
		if (k == 3000) begin
			n_errors++;
			finish_test();
		end
		@(negedge mclk);
		tx_valid = 1'b0;
	endtask

	task automatic wait_idle;
		int k;
		for (k = 0; k < 5000 && ch_q.size() != 0; k++) @(negedge mclk);
		if (k == 5000) begin
			n_errors++;
			finish_test();
		end
		repeat (70) @(negedge mclk);
	endtask

	always @(negedge mclk) begin
		if (reg_rvalid === 1'b1) chk(reg_rdata, (rd_q.size() != 0) ? rd_q.pop_front() : 8'hXX);
	end

	always @(negedge mclk) begin
		logic [16:0] e;
		if (char_done === 1'b1) begin
			e = (ch_q.size() != 0) ? ch_q.pop_front() : 17'h1FFFF;
			chk(char_bits, e[8:0]);
			// first frame of a burst follows idle time, so its gap is not judged
			if (e[16:9] != 8'h00) chk(gap >= e[16:9] && gap <= e[16:9] + 8'h04, 1'b1);
		end
	end

	initial begin
		{rst_n, por_n, sw_rst, reg_wr, reg_rd, page_sel, enh_enable, auto_rts_en} = '0;
		{auto_rts_level, tx_valid, rx_char_valid, rx_char_is_flow, rx_sw_flow_on} = '0;
		{rx_err_push, rx_err_pop, hold_low} = '0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		tx_data = 8'h00;
		mpin = 4'hF;
		bit_clks = 7'd16;
		n_bits = 4'd8;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		por_n = 1'b1;
		rd(ULMC_OFF_LINE_FORMAT, 8'h1D);
		rd(ULMC_OFF_MODEM_CTRL, 8'h00);
		rd(ULMC_OFF_LINE_STATUS, 8'h60);
		for (i = 0; i < 6; i++) begin
			wr(ULMC_OFF_LINE_FORMAT, fmt[i]);
			n_bits = 4'd5 + {2'b00, fmt[i][1:0]} + {3'b000, fmt[i][3]};
			send(fmt[i], 8'h00);
			rd(ULMC_OFF_LINE_STATUS, 8'h20);
			send(fmt[i], !fmt[i][2] ? 8'd16 : (fmt[i][1:0] == 2'b00 ? 8'd24 : 8'd32));
			rd(ULMC_OFF_LINE_STATUS, 8'h00);
			wait_idle();
			rd(ULMC_OFF_LINE_STATUS, 8'h60);
		end
		wr(ULMC_OFF_LINE_FORMAT, 8'h43);
		repeat (3) @(negedge mclk);
		chk(tx_out, 1'b0);
		wr(ULMC_OFF_LINE_FORMAT, 8'h83);
		wr(ULMC_OFF_MODEM_CTRL, 8'h03);
		rd(ULMC_OFF_LINE_STATUS, 8'h00);
		wr(ULMC_OFF_LINE_FORMAT, 8'h03);
		repeat (3) @(negedge mclk);
		chk(tx_out, 1'b1);
		rd(ULMC_OFF_MODEM_CTRL, 8'h00);
		wr(ULMC_OFF_MODEM_CTRL, 8'hFF);
		rd(ULMC_OFF_MODEM_CTRL, 8'h13);
		chk(modem_state, 4'h3);
		chk(sleep_allow, 1'b0);
		enh_enable = 1'b1;
		wr(ULMC_OFF_MODEM_CTRL, 8'h1F);
		#1 chk({modem_state, rx_line}, 5'h1F);
		chk(sleep_allow, 1'b1);
		wr(ULMC_OFF_MODEM_CTRL, 8'h07);
		#1 chk({rts_n_pin, dtr_n_pin, sel_flow_regs}, 3'b001);
		auto_rts_en = 1'b1;
		auto_rts_level = 1'b1;
		#1 chk(rts_n_pin, 1'b1);
		auto_rts_en = 1'b0;
		mpin = 4'b0101;
		repeat (4) @(negedge mclk);
		chk(modem_state, 4'b1010);
		mpin = 4'hF;
		wr(ULMC_OFF_MODEM_CTRL, 8'h80);
		bit_clks = 7'd64;
		n_bits = 4'd8;
		send(8'h03, 8'h00);
		wait_idle();
		bit_clks = 7'd16;
		wr(ULMC_OFF_MODEM_CTRL, 8'h40);
		repeat (4) @(negedge mclk);
		chk({tx_out, rx_line}, 2'b00);
		wr(ULMC_OFF_MODEM_CTRL, 8'h20);
		rx_char_valid = 1'b1;
		#1 chk({tx_resume, rx_fifo_load}, 2'b11);
		rx_char_is_flow = 1'b1;
		rx_sw_flow_on = 1'b1;
		// held across a rising edge so the design's check sees it too
		@(negedge mclk);
		chk({tx_resume, rx_fifo_load}, 2'b10);
		{rx_char_valid, rx_char_is_flow, rx_sw_flow_on} = '0;
		wr(ULMC_OFF_MODEM_CTRL, 8'h00);
		rx_char_valid = 1'b1;
		#1 chk({tx_resume, rx_fifo_load}, 2'b01);
		rx_char_valid = 1'b0;
		rx_err_push = 1'b1;
		@(negedge mclk);
		rx_err_push = 1'b0;
		rd(ULMC_OFF_LINE_STATUS, 8'hE0);
		rx_err_pop = 1'b1;
		@(negedge mclk);
		rx_err_pop = 1'b0;
		rd(ULMC_OFF_LINE_STATUS, 8'h60);
		// break is one full 8N1 frame of 160 clocks; hold it a little longer
		hold_low = 1'b1;
		repeat (200) @(negedge mclk);
		hold_low = 1'b0;
		repeat (4) @(negedge mclk);
		rd(ULMC_OFF_LINE_STATUS, 8'h70);
		rd(ULMC_OFF_LINE_STATUS, 8'h60);
		wr(ULMC_OFF_LINE_FORMAT, ULMC_ENHANCED_KEY);
		wr(ULMC_OFF_MODEM_CTRL, 8'h5A);
		rd(ULMC_OFF_MODEM_CTRL, 8'h5A);
		page_sel = 1'b1;
		rd(ULMC_OFF_MODEM_CTRL, 8'h00);
		page_sel = 1'b0;
		sw_rst = 1'b1;
		@(negedge mclk);
		sw_rst = 1'b0;
		rd(ULMC_OFF_LINE_FORMAT, 8'h1D);
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		wr(ULMC_OFF_LINE_FORMAT, ULMC_ENHANCED_KEY);
		rd(ULMC_OFF_MODEM_CTRL, 8'h5A);
		por_n = 1'b0;
		@(negedge mclk);
		por_n = 1'b1;
		rd(ULMC_OFF_MODEM_CTRL, 8'h00);
		repeat (4) @(negedge mclk);
		finish_test();
	end
endmodule // tb_ulmc_line_modem
`default_nettype wire
